//--- rtl/tcs_pkg.sv
// Purpose: Constants for the text cursor shape block.
// Assumes: Five-bit index and eight-bit data port pair of the display controller.
// Notes: Index values select the two cursor shape registers.
package tcs_pkg;
  localparam logic [4:0] TCS_IDX_START = 5'h0a;
  localparam logic [4:0] TCS_IDX_END = 5'h0b;
  localparam logic [7:0] TCS_START_RST = 8'h00;
  localparam logic [7:0] TCS_END_RST = 8'h00;
  localparam int TCS_ENA_BIT = 5;
  localparam int TCS_LINE_HI = 4;
  localparam int TCS_SKEW_HI = 6;
  localparam int TCS_SKEW_LO = 5;
  localparam logic [7:0] TCS_START_MASK = 8'h3f;
  localparam logic [7:0] TCS_END_MASK = 8'h7f;
  localparam int TCS_SKEW_MAX = 3;
  localparam int TCS_LINE_W = 5;
endpackage

//--- rtl/tcs_delay.sv
// Purpose: Delay line for the cursor flag, one stage per character.
// Assumes: Advanced once per character clock.
// Notes: Tap chosen by the skew field.
`timescale 1ns/1ps
`default_nettype none
module tcs_delay
  import tcs_pkg::*;
#(
  parameter int DEPTH = TCS_SKEW_MAX
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Data.
  input wire logic din,
  input wire logic [1:0] tap,
  output logic dout
);
  logic [DEPTH:0] taps;
  logic [DEPTH-1:0] pipe_ff;
  logic [DEPTH-1:0] nxt_pipe;
  logic dout_ff;
  logic nxt_dout;
  assign taps = {pipe_ff, din};
  always_comb
  begin
    nxt_pipe = taps[DEPTH-1:0];
    // The tap is picked ahead of the output register, so a rewritten skew cannot glitch.
    nxt_dout = taps[tap];
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pipe_ff <= '0;
      dout_ff <= '0;
    end
    else
    begin
      pipe_ff <= nxt_pipe;
      dout_ff <= nxt_dout;
    end
  end
  // Tap zero is one register deep; each higher tap adds one more cycle of latency.
  assign dout = dout_ff;
endmodule
`default_nettype wire

//--- rtl/tcs_top.sv
// Purpose: Text cursor shape control of the display controller.
// Assumes: CLK is the character clock; scan line and cursor match come from the controller.
// Notes: Registers sit behind the controller index/data port pair.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Unused upper bits of both shape registers always read back as zero.
// - Start register bit 5 enables the cursor; zero suppresses it.
// - Start register bits 4:0 give the first cursor scan line.
// - Start line greater than end line means no cursor is drawn.
// - End register bits 6:5 delay the cursor right by whole characters.
module tcs_top
  import tcs_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // Index/data register port.
  input wire logic [4:0] REG_INDEX,
  input wire logic DATA_WR,
  input wire logic [7:0] DATA_WDATA,
  output logic [7:0] DATA_RDATA,
  // Raster position from the controller.
  input wire logic [4:0] SCAN_LINE,
  input wire logic CURSOR_HIT,
  // Cursor output.
  output logic CURSOR_ON
);

  // ****************************************
  // Helper functions
  // ****************************************

  // True when a data port write is aimed at the given register index.
  function automatic logic write_hits(
    input logic wr,
    input logic [4:0] idx,
    input logic [4:0] target
  );
    return wr && (idx == target);
  endfunction

  // Scan line field of either shape register.
  function automatic logic [TCS_LINE_W-1:0] line_field(
    input logic [7:0] shape
  );
    return shape[TCS_LINE_HI:0];
  endfunction

  // True when the start line does not lie below the end line.
  function automatic logic window_ordered(
    input logic [7:0] start_val,
    input logic [7:0] end_val
  );
    return line_field(start_val) <= line_field(end_val);
  endfunction

  // True when a scan line lies between both ends of the window, ends included.
  function automatic logic line_in_window(
    input logic [TCS_LINE_W-1:0] scan,
    input logic [TCS_LINE_W-1:0] first,
    input logic [TCS_LINE_W-1:0] last
  );
    return (scan >= first) && (scan <= last);
  endfunction

  // Reads of any index outside the pair return zero.
  function automatic logic [7:0] read_select(
    input logic [4:0] idx,
    input logic [7:0] start_val,
    input logic [7:0] end_val
  );
    logic [7:0] result;
    case (idx)
      TCS_IDX_START: result = start_val;
      TCS_IDX_END: result = end_val;
      default: result = '0;
    endcase
    return result;
  endfunction

  // ****************************************
  // Register storage
  // ****************************************

  logic [7:0] start_ff;
  logic [7:0] end_ff;
  logic [7:0] nxt_start;
  logic [7:0] nxt_end;
  logic start_wr;
  logic end_wr;

  // Index then data access: the latched index picks the register.
  assign start_wr = write_hits(DATA_WR, REG_INDEX, TCS_IDX_START);
  assign end_wr = write_hits(DATA_WR, REG_INDEX, TCS_IDX_END);

  always_comb
  begin
    nxt_start = start_ff;
    nxt_end = end_ff;
    // Reserved bits are never stored, so they cannot read back as one.
    if (start_wr)
    begin
      nxt_start = DATA_WDATA & TCS_START_MASK;
    end
    if (end_wr)
    begin
      nxt_end = DATA_WDATA & TCS_END_MASK;
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      start_ff <= TCS_START_RST;
      end_ff <= TCS_END_RST;
    end
    else
    begin
      start_ff <= nxt_start;
      end_ff <= nxt_end;
    end
  end

  // ****************************************
  // Window order flag
  // ****************************************

  // Reset shapes are fixed, so their order is known without a comparator.
  localparam logic WINDOW_OK_RST =
    (TCS_START_RST[TCS_LINE_HI:0] <= TCS_END_RST[TCS_LINE_HI:0]);

  logic window_ok_ff;
  logic nxt_window_ok;

  // Registering the order of the stored lines keeps that comparator off the cursor path.
  always_comb
  begin
    nxt_window_ok = window_ordered(nxt_start, nxt_end);
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      window_ok_ff <= WINDOW_OK_RST;
    end
    else
    begin
      window_ok_ff <= nxt_window_ok;
    end
  end

  // ****************************************
  // Read-back path
  // ****************************************

  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // A write in the same cycle is already visible, so software reads what it wrote.
  always_comb
  begin
    nxt_rdata = read_select(REG_INDEX, nxt_start, nxt_end);
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rdata_ff <= '0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign DATA_RDATA = rdata_ff;

  // ****************************************
  // Shape fields
  // ****************************************

  logic cursor_enable;
  logic [TCS_LINE_W-1:0] first_line;
  logic [TCS_LINE_W-1:0] last_line;
  logic [1:0] skew_sel;

  assign cursor_enable = start_ff[TCS_ENA_BIT];
  assign first_line = line_field(start_ff);
  assign last_line = line_field(end_ff);
  assign skew_sel = end_ff[TCS_SKEW_HI:TCS_SKEW_LO];

  // ****************************************
  // Cursor window
  // ****************************************

  logic line_match;
  logic cursor_raw;

  assign line_match = line_in_window(SCAN_LINE, first_line, last_line);
  // An inverted range yields no cursor rather than a wrapped one.
  assign cursor_raw = cursor_enable && CURSOR_HIT
    && window_ok_ff && line_match;

  // ****************************************
  // Skew delay
  // ****************************************

  // Each skew step adds one cycle on top of the one-cycle register latency of tap zero.
  tcs_delay #(
    .DEPTH(TCS_SKEW_MAX)
  ) u_delay (
    .clk(CLK),
    .rst_n(RST_N),
    .din(cursor_raw),
    .tap(skew_sel),
    .dout(CURSOR_ON)
  );

endmodule
`default_nettype wire

//--- sim/tcs_chk.sv
// Purpose: Port checker for tcs_top.
// Assumes: Sees top ports only.
// Notes: Bound after the module.
`timescale 1ns/1ps
`default_nettype none
module tcs_chk
  import tcs_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // Register port.
  input wire logic [4:0] REG_INDEX,
  input wire logic DATA_WR,
  input wire logic [7:0] DATA_WDATA,
  input wire logic [7:0] DATA_RDATA,
  // Cursor.
  input wire logic CURSOR_HIT,
  input wire logic CURSOR_ON
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence wr_s(a); DATA_WR && REG_INDEX == a; endsequence
  a_start_wback: assert property (wr_s(TCS_IDX_START) |=>
    DATA_RDATA == ($past(DATA_WDATA) & 8'h3f)) else $error("start readback");
  a_end_wback: assert property (wr_s(TCS_IDX_END) |=>
    DATA_RDATA == ($past(DATA_WDATA) & 8'h7f)) else $error("end readback");
  a_top_bit: assert property (!DATA_RDATA[7]) else $error("bit 7 set");
  a_other_zero: assert property (REG_INDEX > 5'h0b |=> DATA_RDATA == 8'h00)
    else $error("other index");
  // Four idle cycles cover the longest skew, so the output must be low.
  a_idle_off: assert property (!CURSOR_HIT [*4] |=> !CURSOR_ON)
    else $error("cursor without hit");
  a_reset_off: assert property ($rose(RST_N) |-> !CURSOR_ON)
    else $error("cursor after reset");
endmodule
bind tcs_top tcs_chk u_chk (.CLK, .RST_N, .DATA_WR, .CURSOR_HIT, .CURSOR_ON,
  .REG_INDEX, .DATA_WDATA, .DATA_RDATA);
`default_nettype wire

//--- sim/tb.sv
// Purpose: Bench for tcs_top.
// Assumes: Inputs change 1 ns after the edge.
// Notes: All four skews are swept.
`timescale 1ns/1ps
`default_nettype none
module tb import tcs_pkg::*; ;
  logic CLK = 0, RST_N = 0, DATA_WR = 0, CURSOR_HIT = 0, CURSOR_ON;
  logic [4:0] REG_INDEX = 5'h0a, SCAN_LINE = 5'h00;
  logic [7:0] DATA_WDATA = 8'h00, DATA_RDATA, seen = 8'h00;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  tcs_top uut (.CLK, .RST_N, .REG_INDEX, .DATA_WR, .DATA_WDATA, .DATA_RDATA,
    .SCAN_LINE, .CURSOR_HIT, .CURSOR_ON);
  initial forever #5 CLK = ~CLK;
  task chk(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(logic [4:0] i, logic [7:0] v, logic [7:0] e);
    REG_INDEX = i;
    DATA_WDATA = v;
    DATA_WR = 1;
    @(posedge CLK) #1;
    DATA_WR = 0;
    chk("rdata", e, DATA_RDATA);
    // One idle edge, so a following write never raises the strobe in the same step.
    @(posedge CLK) #1;
  endtask
  task rd(logic [4:0] i, logic [7:0] e);
    REG_INDEX = i;
    @(posedge CLK) #1;
    chk("rdata", e, DATA_RDATA);
  endtask
  // One hit pulse; the bit set in seen marks the cycle the cursor shows.
  task cur(logic [7:0] s, e, logic [4:0] ln, int d);
    wr(TCS_IDX_START, s, s);
    wr(TCS_IDX_END, e, e);
    SCAN_LINE = ln;
    CURSOR_HIT = 1;
    @(posedge CLK) #1;
    CURSOR_HIT = 0;
    for (int k = 0; k < 6; k++)
    begin
      seen[k] = CURSOR_ON;
      @(posedge CLK) #1;
    end
    chk("cursor", d < 0 ? 8'h00 : 8'h01 << d, seen);
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      error_cnt++;
      report_and_stop;
    end
  end
  task test_regs;
    rd(TCS_IDX_START, 8'h00);
    wr(TCS_IDX_START, 8'hff, 8'h3f);
    wr(TCS_IDX_END, 8'hff, 8'h7f);
    wr(5'h0c, 8'h55, 8'h00);
    rd(5'h09, 8'h00);
    rd(TCS_IDX_START, 8'h3f);
    rd(TCS_IDX_END, 8'h7f);
    $display("registers done");
  endtask
  task test_midrun_reset;
    RST_N = 0;
    @(posedge CLK) #1;
    RST_N = 1;
    rd(TCS_IDX_START, 8'h00);
    rd(TCS_IDX_END, 8'h00);
    $display("reset done");
  endtask
  task test_skew;
    for (int k = 0; k < 4; k++) cur(8'h22, 8'(k * 32 + 4), 5'h03, k);
    $display("skew done");
  endtask
  task test_shape;
    cur(8'h02, 8'h04, 5'h03, -1);
    cur(8'h25, 8'h04, 5'h05, -1);
    cur(8'h24, 8'h04, 5'h04, 0);
    cur(8'h22, 8'h04, 5'h05, -1);
    cur(8'h22, 8'h04, 5'h01, -1);
    $display("cursor done");
  endtask
  initial
  begin
    repeat (16) @(posedge CLK);
    #1 RST_N = 1;
    test_regs;
    test_midrun_reset;
    test_skew;
    test_shape;
    report_and_stop;
  end
endmodule
`default_nettype wire
